/* bench/tb_top.sv */
// self-checking testbench for the transceiver channel
`timescale 1ns/1ps
`default_nettype none
`include "txs_cfg.svh"

module tb_top;
	logic i_mclk = 1'b0;
	logic ce = 1'b1;
	logic i_rstn = 1'b0;
	logic go = 1'b0;
	logic pcie = 1'b0;
	logic manual = 1'b1;
	logic valid = 1'b1;
	logic own = 1'b0;
	logic phy_seen = 1'b0;
	txs_pkg::txs_ctrl_type tb_ctrl = 6'h3e;
	txs_pkg::txs_ctrl_type mdl_ctrl;
	txs_pkg::txs_ctrl_type ctrl;
	txs_pkg::txs_recfg_type recfg = 6'h00;
	txs_pkg::txs_stat_type stat;
	logic [1:0] rate;
	logic [4:0] fault;
	int mismatches = 0;
	int checks_done = 0;

	always #50 i_mclk = ~i_mclk;
	assign ctrl = own ? tb_ctrl : mdl_ctrl;
	// phy done is a one-cycle pulse, so it is caught here
	always @(posedge i_mclk) if (stat.phy_done) phy_seen <= 1'b1;

	// documented counts are kept, so the bench runs the real waits
	txs_channel DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(ce), .i_ctrl(ctrl),
		.i_recfg(recfg), .i_pcie_mode(pcie), .i_manual_lock(manual),
		.i_rx_data_valid(valid), .o_stat(stat), .o_tx_rate(rate),
		.o_seq_fault(fault));
	txs_core_model u_core (.i_mclk(i_mclk), .i_go(go), .i_pcie(pcie),
		.i_stat(stat), .o_ctrl(mdl_ctrl));

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_bit(input int idx, input logic val);
		int n;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (stat[idx] !== val && n < 400);
		chk(8'(stat[idx]), 8'(val));
	endtask
	task rst();
		i_rstn <= 1'b0;
		go <= 1'b0;
		own <= 1'b0;
		recfg <= 6'h00;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_mclk);
	endtask
	task recfg_op(input logic [1:0] r, input logic [2:0] m, input logic bump);
		recfg <= {1'b1, r, m};
		@(posedge i_mclk);
		recfg.write_all <= 1'b0;
		@(posedge i_mclk);
		chk(8'(stat.busy), 8'h01);
		// a second request while busy must be ignored
		if (bump)
		begin
			recfg <= {1'b1, 2'h3, m};
			@(posedge i_mclk);
			recfg.write_all <= 1'b0;
		end
		wait_bit(4, 1'b0);
	endtask
	task results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		rst();
		go <= 1'b1;
		wait_bit(7, 1'b1);
		wait_bit(6, 1'b1);
		wait_bit(0, 1'b1);
		chk(8'(fault), 8'h00);
		chk(8'(stat.tx_ready), 8'h01);
		valid <= 1'b0;
		wait_bit(5, 1'b0);
		chk(8'(stat.rx_data_ok), 8'h00);
		valid <= 1'b1;
		wait_bit(5, 1'b1);
		own <= 1'b1;
		tb_ctrl <= 6'h11;
		recfg_op(2'h2, 3'h0, 1'b1);
		chk({6'h00, rate}, 8'h02);
		chk(8'(stat.reconfig_done), 8'h00);
		tb_ctrl <= 6'h01;
		wait_bit(1, 1'b1);
		tb_ctrl <= 6'h1d;
		recfg_op(2'h1, 3'h1, 1'b0);
		chk({5'h00, rate, stat.reconfig_done}, 8'h03);
		tb_ctrl <= 6'h0d;
		repeat (5) @(posedge i_mclk);
		tb_ctrl <= 6'h05;
		wait_bit(5, 1'b1);
		repeat (`TXS_LTD_HOLD_CYC) @(posedge i_mclk);
		tb_ctrl <= 6'h01;
		wait_bit(0, 1'b1);
		chk(8'(fault), 8'h00);
		recfg_op(2'h0, 3'h0, 1'b0);
		chk(8'(stat.reconfig_done), 8'h00);
		rst();
		own <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk(8'(fault), 8'h1f);
		rst();
		pcie <= 1'b1;
		manual <= 1'b0;
		go <= 1'b1;
		wait_bit(0, 1'b1);
		chk({6'h00, phy_seen, fault[4]}, 8'h02);
		// with the enable low the lock must not notice the idle line
		ce <= 1'b0;
		valid <= 1'b0;
		repeat (5) @(posedge i_mclk);
		chk(8'(stat.rx_freq_locked), 8'h01);
		ce <= 1'b1;
		wait_bit(5, 1'b0);
		chk(8'(stat.rx_data_ok), 8'h00);
		own <= 1'b1;
		tb_ctrl <= 6'h02;
		valid <= 1'b1;
		wait_bit(6, 1'b1);
		wait_bit(5, 1'b1);
		repeat (`TXS_LTD_HOLD_CYC) @(posedge i_mclk);
		tb_ctrl <= 6'h06;
		repeat (2) @(posedge i_mclk);
		chk(8'(stat.rx_data_ok), 8'h00);
		tb_ctrl <= 6'h02;
		wait_bit(0, 1'b1);
		chk(8'(fault[4]), 8'h00);
		results();
	end

	initial
	begin
		#1000000;
		mismatches++;
		results();
	end
endmodule

`default_nettype wire

/* bench/txs_channel_monitor.sv */
// concurrent checks on the transceiver channel ports
`timescale 1ns/1ps
`default_nettype none

module txs_channel_monitor #(
	parameter int TX_LOCK_CYC = 4,
	parameter int RECFG_CYC = 4,
	parameter logic [2:0] MODE_CHAN = 3'h1
) (
	input wire logic i_mclk, // clock
	input wire logic i_rstn, // reset, active low
	input wire txs_pkg::txs_ctrl_type i_ctrl, // controls
	input wire txs_pkg::txs_recfg_type i_recfg, // reconfig request
	input wire logic i_pcie_mode, // pcie mode
	input wire txs_pkg::txs_stat_type o_stat, // status
	input wire logic [4:0] o_seq_fault // faults
);
	localparam int TL = TX_LOCK_CYC;
	localparam int BM = RECFG_CYC;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	property p_tx_lock;
		$fell(i_ctrl.pll_powerdown) ##0
			(!i_ctrl.pll_powerdown throughout (##TL 1'b1))
			|-> ##[1:2] o_stat.pll_locked;
	endproperty
	a_tx_lock: assert property (p_tx_lock) else $error("tx lock late");
	property p_rx_lock;
		$rose(o_stat.rx_pll_locked) |-> !$past(i_ctrl.rx_analog_reset, 2)
			&& !$past(i_ctrl.pll_powerdown, 2);
	endproperty
	a_rx_lock: assert property (p_rx_lock) else $error("rx lock early");
	property p_rx_drop;
		i_ctrl.rx_analog_reset [*3] |=> !o_stat.rx_pll_locked;
	endproperty
	a_rx_drop: assert property (p_rx_drop) else $error("rx lock held");
	property p_busy_on;
		$rose(i_recfg.write_all) && !o_stat.busy |=> o_stat.busy;
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy missing");
	property p_busy_len;
		$rose(o_stat.busy) |-> (o_stat.busy throughout (##BM 1'b1))
			##1 !o_stat.busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_done;
		$fell(o_stat.busy) |->
			o_stat.reconfig_done == (i_recfg.mode_sel == MODE_CHAN);
	endproperty
	a_done: assert property (p_done) else $error("done flag wrong");
	property p_phy;
		$fell(i_ctrl.rx_digital_reset) && i_pcie_mode |-> ##[1:2] o_stat.phy_done;
	endproperty
	a_phy: assert property (p_phy) else $error("phy done missing");
	property p_sticky;
		(o_seq_fault & $past(o_seq_fault)) == $past(o_seq_fault);
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault cleared");
endmodule

bind txs_channel txs_channel_monitor #(.TX_LOCK_CYC(TX_LOCK_CYC),
	.RECFG_CYC(RECFG_CYC), .MODE_CHAN(MODE_CHAN)) u_mon (.i_mclk(i_mclk),
	.i_rstn(i_rstn), .i_ctrl(i_ctrl), .i_recfg(i_recfg),
	.i_pcie_mode(i_pcie_mode), .o_stat(o_stat), .o_seq_fault(o_seq_fault));

`default_nettype wire

/* bench/txs_core_model.sv */
// core-side reset controller model driving the channel controls
`timescale 1ns/1ps
`default_nettype none
`include "txs_cfg.svh"

module txs_core_model #(
	parameter int PD_CYC = `TXS_PD_MIN_CYC,
	parameter int LTR_CYC = `TXS_LTR_HOLD_CYC,
	parameter int LTD_CYC = `TXS_LTD_HOLD_CYC
) (
	input wire logic i_mclk, // clock
	input wire logic i_go, // start; low returns to reset
	input wire logic i_pcie, // pcie init sequence
	input wire txs_pkg::txs_stat_type i_stat, // channel status
	output var txs_pkg::txs_ctrl_type o_ctrl // controls
);
	initial forever
	begin
		o_ctrl <= 6'h3e;
		do @(posedge i_mclk); while (!i_go);
		repeat (PD_CYC + 1) @(posedge i_mclk);
		o_ctrl.pll_powerdown <= 1'b0;
		do @(posedge i_mclk); while (!i_stat.pll_locked);
		o_ctrl.tx_digital_reset <= 1'b0;
		do @(posedge i_mclk); while (i_stat.busy);
		o_ctrl.rx_analog_reset <= 1'b0;
		do @(posedge i_mclk); while (!i_stat.rx_pll_locked);
		// pcie init must not wait for frequency lock
		if (!i_pcie)
		begin
			repeat (LTR_CYC + 1) @(posedge i_mclk);
			o_ctrl.lock_to_ref <= 1'b0;
			o_ctrl.lock_to_data <= 1'b1;
			repeat (LTD_CYC + 1) @(posedge i_mclk);
		end
		o_ctrl.rx_digital_reset <= 1'b0;
		do @(posedge i_mclk); while (i_go);
	end
endmodule

`default_nettype wire

/* rtl/txs_cfg.svh */
// timing counts, mode codes and reset values of the transceiver sequencer
`ifndef TXS_CFG_SVH
`define TXS_CFG_SVH

`define TXS_CLK_MHZ 10
`define TXS_TMR_W 8

`define TXS_PD_MIN_US 1
`define TXS_PD_MIN_CYC (`TXS_PD_MIN_US * `TXS_CLK_MHZ)
`define TXS_LTR_HOLD_US 15
`define TXS_LTR_HOLD_CYC (`TXS_LTR_HOLD_US * `TXS_CLK_MHZ)
`define TXS_LTD_HOLD_US 4
`define TXS_LTD_HOLD_CYC (`TXS_LTD_HOLD_US * `TXS_CLK_MHZ)

`define TXS_TX_LOCK_CYC 50
`define TXS_RX_LOCK_CYC 40
`define TXS_FREQ_LOCK_CYC 60
`define TXS_RECFG_CYC 20

`define TXS_MODE_CHAN 3'h1
`define TXS_RATE_RST 2'h0
`define TXS_FLT_W 5
`define TXS_FLT_PD 0
`define TXS_FLT_TXDR 1
`define TXS_FLT_RXAR 2
`define TXS_FLT_LTD 3
`define TXS_FLT_RXDR 4

`endif

/* rtl/txs_channel.sv */
// transceiver channel status model with sequencing watchdog
`timescale 1ns/1ps
`default_nettype none
`include "txs_cfg.svh"

// How it works
// - released power-down lets the transmit PLL lock and flag it
// - released receive analog reset lets the receive PLL lock, flag it
// - PCIe sequence is the same with or without rate-compensation FIFO
// - PCIe: release of receive digital reset makes the channel pulse PHY-done status for one cycle
// - PCIe sequence holds unchanged for one, two, four and eight lanes
// - busy rises on write-all and falls when reconfiguration completes
// - channel reselection raises a done flag at the end
module txs_channel #(
	parameter int TX_LOCK_CYC = `TXS_TX_LOCK_CYC,
	parameter int RX_LOCK_CYC = `TXS_RX_LOCK_CYC,
	parameter int FREQ_LOCK_CYC = `TXS_FREQ_LOCK_CYC,
	parameter int RECFG_CYC = `TXS_RECFG_CYC,
	parameter int PD_MIN_CYC = `TXS_PD_MIN_CYC,
	parameter int LTR_HOLD_CYC = `TXS_LTR_HOLD_CYC,
	parameter int LTD_HOLD_CYC = `TXS_LTD_HOLD_CYC,
	parameter logic [2:0] MODE_CHAN = `TXS_MODE_CHAN
) (
	input wire logic i_mclk, // 10 MHz clock
	input wire logic i_rstn, // asynchronous reset, active low
	input wire logic i_ce, // clock enable, freezes state when low
	input wire txs_pkg::txs_ctrl_type i_ctrl, // reset and lock controls
	input wire txs_pkg::txs_recfg_type i_recfg, // reconfiguration request
	input wire logic i_pcie_mode, // channel runs PCIe
	input wire logic i_manual_lock, // receiver CDR in manual lock mode
	input wire logic i_rx_data_valid, // line carries data, not idle
	output var txs_pkg::txs_stat_type o_stat, // status back to core
	output logic [1:0] o_tx_rate, // rate in force
	output logic [`TXS_FLT_W-1:0] o_seq_fault // sticky sequencing faults
);
	typedef struct packed {
		txs_pkg::txs_stat_type stat;
		logic [1:0] tx_rate;
		logic [1:0] pend_rate;
		logic chan_op;
		logic wa_prev;
		logic pd_prev;
		logic txdr_prev;
		logic rxar_prev;
		logic rxdr_prev;
		logic ltd_prev;
		logic [`TXS_FLT_W-1:0] fault;
	} txs_state_type;

	txs_state_type s;
	txs_state_type next_s;
	logic rst_meta;
	logic rst_n;
	logic tx_lock_done;
	logic rx_lock_done;
	logic freq_done;
	logic busy_done;
	logic pd_done;
	logic ltr_done;
	logic ltd_done;
	logic freq_run;

	// only the second flop is used as reset
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// in manual mode frequency lock needs the CDR switched to data
	assign freq_run = s.stat.rx_pll_locked && i_rx_data_valid &&
		(!i_manual_lock || i_ctrl.lock_to_data);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(TX_LOCK_CYC)) u_tx_lock (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(!i_ctrl.pll_powerdown),
		.o_done(tx_lock_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(RX_LOCK_CYC)) u_rx_lock (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(!i_ctrl.rx_analog_reset && !i_ctrl.pll_powerdown),
		.o_done(rx_lock_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(FREQ_LOCK_CYC)) u_freq (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(freq_run),
		.o_done(freq_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(RECFG_CYC)) u_busy (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(s.stat.busy),
		.o_done(busy_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(PD_MIN_CYC)) u_pd_min (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(i_ctrl.pll_powerdown),
		.o_done(pd_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(LTR_HOLD_CYC)) u_ltr_hold (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(s.stat.rx_pll_locked),
		.o_done(ltr_done)
	);

	txs_lock_timer #(.W(`TXS_TMR_W), .COUNT(LTD_HOLD_CYC)) u_ltd_hold (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_run(i_ctrl.lock_to_data),
		.o_done(ltd_done)
	);

	always_comb
	begin
		next_s = s;
		next_s.wa_prev = i_recfg.write_all;
		next_s.pd_prev = i_ctrl.pll_powerdown;
		next_s.txdr_prev = i_ctrl.tx_digital_reset;
		next_s.rxar_prev = i_ctrl.rx_analog_reset;
		next_s.rxdr_prev = i_ctrl.rx_digital_reset;
		next_s.ltd_prev = i_ctrl.lock_to_data;

		next_s.stat.pll_locked = tx_lock_done;
		next_s.stat.rx_pll_locked = rx_lock_done;
		next_s.stat.rx_freq_locked = freq_done;

		// busy after reset stands for the power-up calibration
		if (i_recfg.write_all && !s.wa_prev && !s.stat.busy)
		begin
			next_s.stat.busy = 1'b1;
			next_s.stat.reconfig_done = 1'b0;
			next_s.pend_rate = i_recfg.rate_sel;
			next_s.chan_op = (i_recfg.mode_sel == MODE_CHAN);
		end
		else if (s.stat.busy && busy_done)
		begin
			next_s.stat.busy = 1'b0;
			next_s.tx_rate = s.pend_rate;
			next_s.stat.reconfig_done = s.chan_op;
		end

		// lane count and rate-match FIFO do not enter here
		next_s.stat.phy_done = i_pcie_mode && s.rxdr_prev &&
			!i_ctrl.rx_digital_reset;

		next_s.stat.tx_ready = tx_lock_done && !i_ctrl.tx_digital_reset &&
			!s.stat.busy;
		next_s.stat.rx_data_ok = freq_done &&
			!i_ctrl.rx_digital_reset;

		// faults are set-only and cleared by reset alone
		if (s.pd_prev && !i_ctrl.pll_powerdown && !pd_done)
		begin
			next_s.fault[`TXS_FLT_PD] = 1'b1;
		end
		if (s.txdr_prev && !i_ctrl.tx_digital_reset &&
			(!s.stat.pll_locked || s.stat.busy))
		begin
			next_s.fault[`TXS_FLT_TXDR] = 1'b1;
		end
		if (s.rxar_prev && !i_ctrl.rx_analog_reset && s.stat.busy)
		begin
			next_s.fault[`TXS_FLT_RXAR] = 1'b1;
		end
		if (i_manual_lock && !s.ltd_prev && i_ctrl.lock_to_data && !ltr_done)
		begin
			next_s.fault[`TXS_FLT_LTD] = 1'b1;
		end
		if (s.rxdr_prev && !i_ctrl.rx_digital_reset &&
			(i_pcie_mode ? !s.stat.rx_pll_locked :
			(i_manual_lock && !ltd_done)))
		begin
			next_s.fault[`TXS_FLT_RXDR] = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.stat.busy <= 1'b1;
			s.tx_rate <= `TXS_RATE_RST;
			s.pend_rate <= `TXS_RATE_RST;
			s.pd_prev <= 1'b1;
			s.txdr_prev <= 1'b1;
			s.rxar_prev <= 1'b1;
			s.rxdr_prev <= 1'b1;
		end
		else if (i_ce)
		begin
			s <= next_s;
		end
	end

	assign o_stat = s.stat;
	assign o_tx_rate = s.tx_rate;
	assign o_seq_fault = s.fault;
endmodule

`default_nettype wire

/* rtl/txs_lock_timer.sv */
// elapsed-time timer: done rises COUNT cycles after run rises
`timescale 1ns/1ps
`default_nettype none

module txs_lock_timer #(
	parameter int W = 8,
	parameter int COUNT = 10
) (
	input wire logic i_mclk, // clock
	input wire logic i_rst_n, // synchronised reset, active low
	input wire logic i_ce, // clock enable
	input wire logic i_run, // count while high, clear while low
	output logic o_done // count reached
);
	localparam logic [W-1:0] LIM = COUNT[W-1:0];

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} txs_tmr_state_type;

	txs_tmr_state_type s;
	txs_tmr_state_type next_s;

	always_comb
	begin
		next_s = s;
		if (!i_run)
		begin
			next_s.cnt = '0;
		end
		else if (s.cnt != LIM)
		begin
			next_s.cnt = s.cnt + 1'b1;
		end
		next_s.done = i_run && (next_s.cnt == LIM);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s <= '0;
		end
		else if (i_ce)
		begin
			s <= next_s;
		end
	end

	assign o_done = s.done;
endmodule

`default_nettype wire

/* rtl/txs_pkg.sv */
// carrier types of the transceiver sequencer
package txs_pkg;

	typedef struct packed {
		logic pll_powerdown;
		logic tx_digital_reset;
		logic rx_analog_reset;
		logic rx_digital_reset;
		logic lock_to_ref;
		logic lock_to_data;
	} txs_ctrl_type;

	typedef struct packed {
		logic write_all;
		logic [1:0] rate_sel;
		logic [2:0] mode_sel;
	} txs_recfg_type;

	typedef struct packed {
		logic pll_locked;
		logic rx_pll_locked;
		logic rx_freq_locked;
		logic busy;
		logic reconfig_done;
		logic phy_done;
		logic tx_ready;
		logic rx_data_ok;
	} txs_stat_type;

endpackage
